//--- logic/tpwm_regs.svh
// register offsets, field positions, reset values and timing counts of the modulator block
`ifndef TPWM_REGS_SVH
`define TPWM_REGS_SVH

// apb byte offsets
`define TPWM_CTRL0_OFS 8'h00
`define TPWM_DHI0_OFS 8'h04
`define TPWM_DLO0_OFS 8'h08
`define TPWM_CTRL1_OFS 8'h0C
`define TPWM_DHI1_OFS 8'h10
`define TPWM_DLO1_OFS 8'h14
`define TPWM_TSEL_OFS 8'h18
`define TPWM_PIN_OFS 8'h1C
`define TPWM_TMR_BASE 8'h20
`define TPWM_TMR_STRIDE 8'h10
// per-timer offsets relative to its base
`define TPWM_PER_SUB 4'h0
`define TPWM_CNT_SUB 4'h4
`define TPWM_TCTL_SUB 4'h8
`define TPWM_FLAG_SUB 4'hC

// field positions
`define TPWM_EN_BIT 7
`define TPWM_OUT_BIT 5
`define TPWM_POL_BIT 4
`define TPWM_RUN_BIT 7
`define TPWM_PSC_LSB 4
`define TPWM_DLO_LSB 6

// reset values
`define TPWM_TSEL_RST 4'h5
`define TPWM_PER_RST 8'hFF
`define TPWM_DIR_RST 2'h3

// fine counter: four input clocks per instruction cycle
`define TPWM_CLK_PER_INSN 9'h004
`endif

//--- logic/tpwm_pkg.sv
// types shared by the modulator block
`default_nettype none
package tpwm_pkg;
  // one modulator channel
  typedef struct packed {
    logic en;
    logic pol;
    logic out;
    logic [7:0] dhi;
    logic [1:0] dlo;
    logic [9:0] dbuf;
  } tpwm_mod_t;

  // one shared 8-bit period timer
  typedef struct packed {
    logic run;
    logic [2:0] psc;
    logic [7:0] per;
    logic [7:0] cnt;
    logic [8:0] fine;
    logic flag;
  } tpwm_tmr_t;

  // whole block state
  typedef struct packed {
    tpwm_mod_t [1:0] m;
    tpwm_tmr_t [2:0] t;
    logic [3:0] tsel;
    logic [1:0] dir;
    logic [1:0] route;
    logic [1:0] latch;
    logic [2:0] slp_sync;
    logic slp;
    logic [31:0] rdata;
  } tpwm_state_t;

  // register selected by an apb address
  typedef enum {
    TPWM_R_NONE, TPWM_R_CTRL, TPWM_R_DHI, TPWM_R_DLO, TPWM_R_TSEL, TPWM_R_PIN,
    TPWM_R_PER, TPWM_R_CNT, TPWM_R_TCTL, TPWM_R_FLAG
  } tpwm_reg_e;

  // decoded register and its channel or timer index
  typedef struct packed {
    tpwm_reg_e kind;
    logic [1:0] idx;
  } tpwm_dec_t;
endpackage : tpwm_pkg
`default_nettype wire

//--- logic/tpwm_top.sv
// two-channel timer-based pulse-width modulator with three shared period timers and apb access
//
// Overview of operation
// - timer wrap sets every enabled output using it whose duty is nonzero
// - output clears when time base equals duty
// - duty at or above period gives full duty
// - after period match: clear, latch, set output
// - compare only buffered duty, refreshed at match
// - duty writes never disturb current period
// - polarity bit inverts the output
// - per-channel timer select, defaults first timer
// - period shared, duty per channel
// - ten-bit resolution when period is 255
// - period is (limit+1) x4 x prescale clocks
// - time base: count plus two fine bits
// - no postscaler in the waveform
// - sleep freezes timer and output
// - reset returns all registers to defaults
// - pin muxed with port latch, direction gated
// - enable bit turns the channel on
// - read-only bit shows output level
//
// Design decisions made here: the register addresses and the APB slave port.
`include "tpwm_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module tpwm_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // power state
  input wire logic sleep_req,
  // channel outputs to on-chip peripherals
  output logic [1:0] modulator_output,
  // port pins
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe
);

  tpwm_pkg::tpwm_state_t s_q;
  tpwm_pkg::tpwm_state_t s_d;
  tpwm_pkg::tpwm_dec_t wdec;
  tpwm_pkg::tpwm_dec_t rdec;
  logic wr_en;
  logic [2:0] wrap_t;
  logic [2:0] act_t;
  logic [9:0] tb_t [3];
  logic [8:0] fmax_t [3];
  logic [1:0] wrap_m;
  logic [1:0] act_m;
  logic [9:0] tb_m [2];
  logic [8:0] nfine_t [3];
  logic [9:0] ntb_t [3];
  logic [9:0] ntb_m [2];

  // address decode shared by the read and write paths
  function automatic tpwm_pkg::tpwm_dec_t reg_decode(input logic [7:0] a);
    tpwm_pkg::tpwm_dec_t r;
    logic [7:0] rel;
    r.kind = tpwm_pkg::TPWM_R_NONE;
    r.idx = 2'h0;
    rel = a - `TPWM_TMR_BASE;
    if (a == `TPWM_CTRL0_OFS || a == `TPWM_CTRL1_OFS) begin
      r.kind = tpwm_pkg::TPWM_R_CTRL;
      r.idx = {1'b0, a == `TPWM_CTRL1_OFS};
    end else if (a == `TPWM_DHI0_OFS || a == `TPWM_DHI1_OFS) begin
      r.kind = tpwm_pkg::TPWM_R_DHI;
      r.idx = {1'b0, a == `TPWM_DHI1_OFS};
    end else if (a == `TPWM_DLO0_OFS || a == `TPWM_DLO1_OFS) begin
      r.kind = tpwm_pkg::TPWM_R_DLO;
      r.idx = {1'b0, a == `TPWM_DLO1_OFS};
    end else if (a == `TPWM_TSEL_OFS) begin
      r.kind = tpwm_pkg::TPWM_R_TSEL;
    end else if (a == `TPWM_PIN_OFS) begin
      r.kind = tpwm_pkg::TPWM_R_PIN;
    end else if (a >= `TPWM_TMR_BASE && rel < 8'h30 && a[1:0] == 2'h0) begin
      r.idx = rel[5:4];
      if (rel[3:0] == `TPWM_PER_SUB) begin
        r.kind = tpwm_pkg::TPWM_R_PER;
      end else if (rel[3:0] == `TPWM_CNT_SUB) begin
        r.kind = tpwm_pkg::TPWM_R_CNT;
      end else if (rel[3:0] == `TPWM_TCTL_SUB) begin
        r.kind = tpwm_pkg::TPWM_R_TCTL;
      end else begin
        r.kind = tpwm_pkg::TPWM_R_FLAG;
      end
    end
    return r;
  endfunction : reg_decode

  // timer index chosen by a two-bit select field; zero selects no timer
  function automatic logic [1:0] sel_timer(input logic [1:0] f);
    return (f == 2'h0) ? 2'h3 : 2'(f - 2'h1);
  endfunction : sel_timer

  assign wdec = reg_decode(paddr);
  assign rdec = wdec;
  assign wr_en = psel && penable && pwrite;

  // apb handshake: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && (wdec.kind == tpwm_pkg::TPWM_R_NONE);
  assign prdata = s_q.rdata;

  // per-timer wrap, activity and ten-bit time base; postscaler takes no part
  for (genvar i = 0; i < 3; i++) begin : g_tmr
    assign fmax_t[i] = 9'((`TPWM_CLK_PER_INSN << s_q.t[i].psc) - 9'h001);
    assign act_t[i] = s_q.t[i].run && !s_q.slp;
    assign wrap_t[i] = act_t[i] && (s_q.t[i].fine == fmax_t[i])
                       && (s_q.t[i].cnt == s_q.t[i].per);
    assign tb_t[i] = {s_q.t[i].cnt, 2'(s_q.t[i].fine >> s_q.t[i].psc)};
    // time base of the next clock, so the output is already low while it equals the duty
    assign nfine_t[i] = (s_q.t[i].fine == fmax_t[i]) ? 9'h000 : 9'(s_q.t[i].fine + 9'h001);
    assign ntb_t[i] = {((s_q.t[i].fine == fmax_t[i]) ? 8'(s_q.t[i].cnt + 8'h01) : s_q.t[i].cnt),
                       2'(nfine_t[i] >> s_q.t[i].psc)};
  end

  // per-channel view of its selected timer
  for (genvar j = 0; j < 2; j++) begin : g_mod
    logic [1:0] ti;
    assign ti = sel_timer(s_q.tsel[2*j +: 2]);
    assign wrap_m[j] = (ti != 2'h3) && wrap_t[ti];
    assign act_m[j] = (ti != 2'h3) && act_t[ti];
    assign tb_m[j] = (ti != 2'h3) ? tb_t[ti] : 10'h000;
    assign ntb_m[j] = (ti != 2'h3) ? ntb_t[ti] : 10'h000;
    assign modulator_output[j] = s_q.m[j].out ^ s_q.m[j].pol;
    assign pin_out[j] = s_q.route[j] ? modulator_output[j] : s_q.latch[j];
    assign pin_oe[j] = !s_q.dir[j];
  end

  // next-state logic: sync, timers, channels, register writes, read capture
  always_comb begin
    s_d = s_q;
    // sleep request: three flops, accepted once the last two agree
    s_d.slp_sync = {s_q.slp_sync[1:0], sleep_req};
    if (s_q.slp_sync[1] == s_q.slp_sync[2]) begin
      s_d.slp = s_q.slp_sync[2];
    end
    // shared timers
    for (int i = 0; i < 3; i++) begin
      if (act_t[i]) begin
        if (s_q.t[i].fine == fmax_t[i]) begin
          s_d.t[i].fine = 9'h000;
          if (wrap_t[i]) begin
            s_d.t[i].cnt = 8'h00;
            s_d.t[i].flag = 1'b1;
          end else begin
            s_d.t[i].cnt = 8'(s_q.t[i].cnt + 8'h01);
          end
        end else begin
          s_d.t[i].fine = 9'(s_q.t[i].fine + 9'h001);
        end
      end
    end
    // channels
    for (int j = 0; j < 2; j++) begin
      if (wrap_m[j]) begin
        s_d.m[j].dbuf = {s_q.m[j].dhi, s_q.m[j].dlo};
        s_d.m[j].out = s_q.m[j].en && ({s_q.m[j].dhi, s_q.m[j].dlo} != 10'h000);
      end else if (act_m[j] && ntb_m[j] == s_q.m[j].dbuf) begin
        s_d.m[j].out = 1'b0;
      end
      if (!s_q.m[j].en) begin
        s_d.m[j].out = 1'b0;
      end
    end
    // register writes take effect at the access edge
    if (wr_en) begin
      case (wdec.kind)
        tpwm_pkg::TPWM_R_CTRL: begin
          s_d.m[wdec.idx[0]].en = pwdata[`TPWM_EN_BIT];
          s_d.m[wdec.idx[0]].pol = pwdata[`TPWM_POL_BIT];
        end
        tpwm_pkg::TPWM_R_DHI: begin
          s_d.m[wdec.idx[0]].dhi = pwdata[7:0];
        end
        tpwm_pkg::TPWM_R_DLO: begin
          s_d.m[wdec.idx[0]].dlo = pwdata[`TPWM_DLO_LSB +: 2];
        end
        tpwm_pkg::TPWM_R_TSEL: begin
          s_d.tsel = pwdata[3:0];
        end
        tpwm_pkg::TPWM_R_PIN: begin
          s_d.dir = pwdata[1:0];
          s_d.route = pwdata[5:4];
          s_d.latch = pwdata[9:8];
        end
        tpwm_pkg::TPWM_R_PER: begin
          s_d.t[wdec.idx].per = pwdata[7:0];
        end
        tpwm_pkg::TPWM_R_CNT: begin
          s_d.t[wdec.idx].cnt = pwdata[7:0];
          s_d.t[wdec.idx].fine = 9'h000;
        end
        tpwm_pkg::TPWM_R_TCTL: begin
          s_d.t[wdec.idx].run = pwdata[`TPWM_RUN_BIT];
          s_d.t[wdec.idx].psc = pwdata[`TPWM_PSC_LSB +: 3];
        end
        tpwm_pkg::TPWM_R_FLAG: begin
          // write one clears, a wrap in the same cycle wins
          if (pwdata[0] && !wrap_t[wdec.idx]) begin
            s_d.t[wdec.idx].flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // read data captured in the setup cycle
    if (psel && !penable) begin
      s_d.rdata = 32'h0000_0000;
      case (rdec.kind)
        tpwm_pkg::TPWM_R_CTRL: begin
          s_d.rdata[`TPWM_EN_BIT] = s_q.m[rdec.idx[0]].en;
          s_d.rdata[`TPWM_OUT_BIT] = modulator_output[rdec.idx[0]];
          s_d.rdata[`TPWM_POL_BIT] = s_q.m[rdec.idx[0]].pol;
        end
        tpwm_pkg::TPWM_R_DHI: begin
          s_d.rdata[7:0] = s_q.m[rdec.idx[0]].dhi;
        end
        tpwm_pkg::TPWM_R_DLO: begin
          s_d.rdata[`TPWM_DLO_LSB +: 2] = s_q.m[rdec.idx[0]].dlo;
        end
        tpwm_pkg::TPWM_R_TSEL: begin
          s_d.rdata[3:0] = s_q.tsel;
        end
        tpwm_pkg::TPWM_R_PIN: begin
          s_d.rdata[1:0] = s_q.dir;
          s_d.rdata[5:4] = s_q.route;
          s_d.rdata[9:8] = s_q.latch;
        end
        tpwm_pkg::TPWM_R_PER: begin
          s_d.rdata[7:0] = s_q.t[rdec.idx].per;
        end
        tpwm_pkg::TPWM_R_CNT: begin
          s_d.rdata[7:0] = s_q.t[rdec.idx].cnt;
        end
        tpwm_pkg::TPWM_R_TCTL: begin
          s_d.rdata[`TPWM_RUN_BIT] = s_q.t[rdec.idx].run;
          s_d.rdata[`TPWM_PSC_LSB +: 3] = s_q.t[rdec.idx].psc;
        end
        tpwm_pkg::TPWM_R_FLAG: begin
          s_d.rdata[0] = s_q.t[rdec.idx].flag;
        end
        default: begin
        end
      endcase
    end
  end

  // state register with reset defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.tsel <= `TPWM_TSEL_RST;
      s_q.dir <= `TPWM_DIR_RST;
      for (int i = 0; i < 3; i++) begin
        s_q.t[i].per <= `TPWM_PER_RST;
      end
    end else begin
      s_q <= s_d;
    end
  end

  // checks on channel 0 and timer 0
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_wrap_clears_count: assert property (wrap_t[0] |=> s_q.t[0].cnt == 8'h00)
    else $error("timer count not cleared after period match");

  a_wrap_latch_duty: assert property (wrap_m[0] && !wr_en |=>
      s_q.m[0].dbuf == $past({s_q.m[0].dhi, s_q.m[0].dlo}))
    else $error("duty buffer not refreshed at period match");

  a_buffer_holds: assert property (!wrap_m[0] |=> $stable(s_q.m[0].dbuf))
    else $error("duty buffer changed outside a period match");

  a_wrap_sets_out: assert property (wrap_m[0] && s_q.m[0].en && !wr_en
      && {s_q.m[0].dhi, s_q.m[0].dlo} != 10'h000 |=> s_q.m[0].out)
    else $error("output not set at period start");

  a_zero_duty_low: assert property (wrap_m[0] && {s_q.m[0].dhi, s_q.m[0].dlo} == 10'h000
      |=> !s_q.m[0].out)
    else $error("zero duty output went active");

  a_match_clears: assert property (act_m[0] && !wrap_m[0] && s_q.m[0].out
      && ntb_m[0] == s_q.m[0].dbuf |=> !s_q.m[0].out)
    else $error("output not cleared on duty match");

  a_full_duty_holds: assert property (s_q.m[0].out && !wrap_m[0] && s_q.m[0].en
      && s_q.m[0].dbuf > {s_q.t[0].per, 2'h3} && s_q.tsel[1:0] == 2'h1
      && !wr_en |=> s_q.m[0].out)
    else $error("full duty output dropped inside period");

  a_disabled_idle: assert property (!s_q.m[0].en ##1 !s_q.m[0].en |->
      modulator_output[0] == s_q.m[0].pol)
    else $error("disabled channel not at inactive level");

  a_sleep_freezes: assert property (s_q.slp && !wr_en |=>
      $stable(s_q.t[0].cnt) && $stable(s_q.m[0].out))
    else $error("timer or output moved during sleep");

  a_count_rate: assert property ($changed(s_q.t[0].cnt) && !$past(wr_en) |->
      $past(s_q.t[0].fine) == $past(fmax_t[0]))
    else $error("timer advanced before prescale period ended");

endmodule : tpwm_top
`default_nettype wire

//--- sim/tpwm_load_model.sv
// load model at the modulator output: measures period and high time of a waveform
`timescale 1ns/10ps
`default_nettype none

module tpwm_load_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // observed waveform
  input wire logic sig,
  // measured lengths in clocks, updated at each rising edge of sig
  output logic [15:0] per_len,
  output logic [15:0] hi_len
);
  logic prev_q;
  logic [15:0] cnt_q;
  logic [15:0] hcnt_q;

  // count clocks between rising edges and the high clocks among them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
      cnt_q <= 16'h0000;
      hcnt_q <= 16'h0000;
      per_len <= 16'h0000;
      hi_len <= 16'h0000;
    end else begin
      prev_q <= sig;
      cnt_q <= cnt_q + 16'h0001;
      if (sig) begin
        hcnt_q <= hcnt_q + 16'h0001;
      end
      if (sig && !prev_q) begin
        per_len <= cnt_q;
        hi_len <= hcnt_q;
        cnt_q <= 16'h0001;
        hcnt_q <= 16'h0001;
      end
    end
  end
endmodule : tpwm_load_model
`default_nettype wire

//--- sim/timer_based_pwm_generator_tb_top.sv
// self-checking testbench of the modulator block over apb
`include "tpwm_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module timer_based_pwm_generator_tb_top;
  localparam logic [7:0] T0_PER = 8'h20;
  localparam logic [7:0] T0_CNT = 8'h24;
  localparam logic [7:0] T0_CTL = 8'h28;
  localparam logic [7:0] T0_FLG = 8'h2C;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_req, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, rd2;
  logic [1:0] modulator_output, pin_out, pin_oe;
  logic [15:0] per_len, hi_len;
  int mismatches = 0;
  int cmp_count = 0;

  tpwm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_req(sleep_req), .modulator_output(modulator_output),
    .pin_out(pin_out), .pin_oe(pin_oe));
  tpwm_load_model load (.pclk(pclk), .presetn(presetn), .sig(modulator_output[0]),
    .per_len(per_len), .hi_len(hi_len));

  // clock at 4 ns
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt

  // sample one output for 40 clocks and count samples off the expected level
  task automatic hold_chk(input int idx, input logic v);
    int bad;
    bad = 0;
    repeat (40) begin
      @(posedge pclk);
      if (modulator_output[idx] !== v) bad++;
    end
    chk(bad, 0);
  endtask : hold_chk

  // watchdog
  initial begin
    wt(20000);
    mismatches++;
    close_out();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sleep_req = 1'b0;
    wt(5);
    presetn <= 1'b1;
    apb(0, `TPWM_TSEL_OFS, 0); chk(rd, 32'h5);
    apb(0, `TPWM_PIN_OFS, 0); chk(rd, 32'h3);
    apb(0, T0_PER, 0); chk(rd, 32'hFF);
    apb(0, `TPWM_CTRL0_OFS, 0); chk(rd, 32'h0);
    apb(0, 8'hF0, 0); chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // setup order for pin use: period 3, ch0 duty 6, ch1 duty 16 (full)
    apb(1, `TPWM_CTRL0_OFS, 0);
    apb(1, T0_PER, 32'h3);
    apb(1, `TPWM_DHI0_OFS, 32'h1);
    apb(1, `TPWM_DLO0_OFS, 32'h80);
    apb(1, `TPWM_DHI1_OFS, 32'h4);
    apb(1, `TPWM_DLO1_OFS, 32'h0);
    apb(1, T0_FLG, 32'h1);
    apb(1, T0_CTL, 32'h80);
    for (int i = 0; i < 50 && rd[0] !== 1'b1; i++) apb(0, T0_FLG, 0);
    chk(rd, 32'h1);
    apb(1, `TPWM_CTRL0_OFS, 32'h80);
    apb(1, `TPWM_CTRL1_OFS, 32'h80);
    wt(60);
    chk({per_len, hi_len}, {16'd16, 16'd6});
    hold_chk(1, 1'b1);
    apb(0, `TPWM_CTRL1_OFS, 0); chk(rd, 32'hA0);
    apb(1, `TPWM_CTRL0_OFS, 32'h90);
    wt(60);
    chk({per_len, hi_len}, {16'd16, 16'd10});
    apb(1, `TPWM_CTRL0_OFS, 32'h80);
    apb(1, `TPWM_DHI0_OFS, 32'h0);
    apb(1, `TPWM_DLO0_OFS, 32'h80);
    wt(60);
    chk({per_len, hi_len}, {16'd16, 16'd2});
    apb(1, `TPWM_DLO0_OFS, 32'h0);
    wt(40);
    hold_chk(0, 1'b0);
    apb(1, `TPWM_DHI0_OFS, 32'h1);
    apb(1, `TPWM_DLO0_OFS, 32'h80);
    apb(1, T0_CTL, 32'h90);
    wt(120);
    chk({per_len, hi_len}, {16'd32, 16'd12});
    apb(1, `TPWM_CTRL0_OFS, 32'h10);
    wt(2);
    hold_chk(0, 1'b1);
    apb(1, `TPWM_CTRL0_OFS, 32'h00);
    wt(2);
    hold_chk(0, 1'b0);
    apb(1, `TPWM_PIN_OFS, 32'h120);
    wt(2);
    chk({pin_oe, pin_out}, 4'hF);
    apb(1, `TPWM_PIN_OFS, 32'h123);
    wt(2);
    chk(pin_oe, 2'b00);
    sleep_req <= 1'b1;
    wt(8);
    apb(0, T0_CNT, 0);
    rd2 = rd;
    wt(10);
    apb(0, T0_CNT, 0); chk(rd, rd2);
    sleep_req <= 1'b0;
    apb(1, `TPWM_TSEL_OFS, 32'h1);
    wt(40);
    hold_chk(1, 1'b1);
    close_out();
  end
endmodule : timer_based_pwm_generator_tb_top
`default_nettype wire
